/* File: rtl/afe_out_pkg.sv */
// constants, register map and carrier types of the front end control block
//
// Contract
// R1: capture word at selected output latch phase
// R2: transparent bit passes converter words straight
// R3: disable bit three-states all pixel outputs; code three-states PIX_DATA only, holds PIX_VALID low, word clock keeps running
// R4: binary by default, gray when bit set
// R5: word clock tracks output latch phase
// R6: fixed select pins word clock phase
// R7: invert bit flips word clock polarity
// R8: latch phase near reference sample edge
// R9: latch phase away from level sample edge
// R10: clamp enable bit turns loop off
// R11: disabled loop still applies level offset
// R12: compare black pixels, feed filtered correction
// R13: black target 0..255 LSB, 1023 steps
// R14: loop updates per line or slower
// R15: clamp pulse covers black, 20 pixels
// R16: dc restore closes during reference pulse
// R17: register bit gates restore during preblank
// R18: preblank grounds the sampler input
// R19: no clamp pulse while preblank active
// R20: sample edges from two location fields
// R21: three sampler gain steps, 0 dB default
// R22: ten-bit amplifier gain code
// R23: gray is bit xor next higher bit
// R24: three-state disable overrides every other setting
package afe_out_pkg;
  // register offsets of the serial map
  localparam logic [7:0] ADDR_POWER_CLAMP = 8'h00;
  localparam logic [7:0] ADDR_OUT_FORMAT = 8'h01;
  localparam logic [7:0] ADDR_CLAMP_LEVEL = 8'h03;
  localparam logic [7:0] ADDR_SAMPLER_GAIN = 8'h04;
  localparam logic [7:0] ADDR_AMP_GAIN = 8'h05;
  localparam logic [7:0] ADDR_EDGE_LOC = 8'h37;
  // field positions
  localparam int BIT_CLAMP_EN = 2;
  localparam int BIT_RESTORE_OFF_PREBLANK_PULSE = 6;
  localparam int POS_UPDATE_DIV = 4;
  localparam int BIT_OUT_DISABLE = 0;
  localparam int BIT_TRANSPARENT = 1;
  localparam int BIT_GRAY = 2;
  localparam int BIT_CLK_FIXED = 3;
  localparam int BIT_CLK_INVERT = 4;
  localparam int POS_REF_LOC = 0;
  localparam int POS_LEVEL_LOC = 8;
  localparam int POS_LATCH_PHASE = 16;
  // reset values
  localparam logic [7:0] RST_POWER_CLAMP = 8'h04;
  localparam logic [7:0] RST_OUT_FORMAT = 8'h00;
  localparam logic [9:0] RST_CLAMP_LEVEL = 10'h000;
  localparam logic [1:0] RST_SAMPLER_GAIN = 2'h1;
  localparam logic [9:0] RST_AMP_GAIN = 10'h000;
  localparam logic [23:0] RST_EDGE_LOC = 24'h002000;
  // sampler gain codes
  localparam logic [1:0] GAIN_MINUS3 = 2'h0;
  localparam logic [1:0] GAIN_ZERO = 2'h1;
  localparam logic [1:0] GAIN_PLUS3 = 2'h2;
  // black target scale: code 1023 maps to 255 LSB
  localparam int TARGET_FULL_LSB = 255;
  localparam int TARGET_FULL_CODE = 1023;
  // serial frame: 8 address bits then 24 data bits
  localparam int FRAME_BITS = 32;
  // one decoded register write
  typedef struct packed {
    logic [7:0] addr;
    logic [23:0] data;
  } reg_write_type;
endpackage : afe_out_pkg

/* File: rtl/word_buffer.sv */
// two-entry valid/ready buffer in the pixel word path
`timescale 1ns/1ps
`default_nettype none
module word_buffer #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 2
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;
  // full and empty are honest: taken from the entry count
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop) rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
      in_ready <= (count + (PW+1)'(push) - (PW+1)'(pop)) != (PW+1)'(DEPTH);
      out_valid <= (count + (PW+1)'(push) - (PW+1)'(pop)) != '0;
    end
  end
  // storage written only on accepted words
  always_ff @(posedge CLK) begin
    if (push) mem[wr_ptr] <= in_data;
  end
endmodule // word_buffer
`default_nettype wire

/* File: rtl/afe_out_ctrl.sv */
// front end control: serial registers, sample edges, clamp loop, pixel output
`timescale 1ns/1ps
`default_nettype none
module afe_out_ctrl #(
  parameter int DATA_W = 14,
  parameter int PHASE_W = 6,
  parameter int PULSE_W = 8,
  parameter int FILT_SHIFT = 4,
  parameter int CORR_W = 12
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic SL_N,
  input wire logic SCK,
  input wire logic SDI,
  input wire logic [DATA_W-1:0] ADC_DATA,
  input wire logic ADC_VALID,
  output logic ADC_READY,
  input wire logic PIX_READY,
  input wire logic PREBLANK_PULSE_N,
  input wire logic BLACK_CLAMP_PULSE,
  output logic [DATA_W-1:0] PIX_DATA,
  output logic PIX_DATA_OE,
  output logic PIX_VALID,
  output logic PIXEL_WORD_CLOCK_OUT,
  output logic REFERENCE_SAMPLE_PULSE,
  output logic LEVEL_SAMPLE_PULSE,
  output logic DC_RESTORE_CLOSE,
  output logic INPUT_GROUND,
  output logic [1:0] SAMPLER_GAIN,
  output logic [9:0] AMP_GAIN,
  output logic signed [CORR_W-1:0] CLAMP_DAC
);
  localparam logic [PHASE_W-1:0] HALF = PHASE_W'(1 << (PHASE_W - 1));
  localparam logic [PHASE_W-1:0] PW_C = PHASE_W'(PULSE_W);

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers: two flops before any logic
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic sck_prev;
  logic sl_prev;
  logic clamp_prev;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sync1 <= 5'h19; // idle levels: load high, preblank off, sck low
      sync2 <= 5'h19;
      sck_prev <= 1'b0;
      sl_prev <= 1'b1;
      clamp_prev <= 1'b0;
    end else begin
      sync1 <= {SL_N, PREBLANK_PULSE_N, BLACK_CLAMP_PULSE, SCK, SDI};
      sync2 <= sync1;
      sck_prev <= sync2[1];
      sl_prev <= sync2[4];
      clamp_prev <= sync2[2];
    end
  end
  wire sdi_s = sync2[0];
  wire sck_s = sync2[1];
  wire clamp_s = sync2[2];
  wire preblank_pulse_active = !sync2[3];
  wire sl_n_s = sync2[4];
  wire sck_rise = sck_s && !sck_prev;
  wire frame_end = sl_n_s && !sl_prev;
  wire clamp_fall = !clamp_s && clamp_prev;

  //////////////////////////////////////////////////////////////////////
  // serial write port: msb first, address then data, taken at load end
  localparam int FRAME_BITS_W = $clog2(afe_out_pkg::FRAME_BITS);
  logic [FRAME_BITS_W:0] bit_cnt;
  logic [afe_out_pkg::FRAME_BITS-1:0] shift;
  afe_out_pkg::reg_write_type wr;
  logic wr_fire;
  assign wr = afe_out_pkg::reg_write_type'(shift);
  assign wr_fire = frame_end
    && (bit_cnt == (FRAME_BITS_W+1)'(afe_out_pkg::FRAME_BITS));
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      shift <= '0;
      bit_cnt <= '0;
    end else if (sl_n_s) begin
      bit_cnt <= '0;
    end else if (sck_rise) begin
      shift <= {shift[afe_out_pkg::FRAME_BITS-2:0], sdi_s};
      if (bit_cnt != (FRAME_BITS_W+1)'(afe_out_pkg::FRAME_BITS))
        bit_cnt <= bit_cnt + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // register file
  logic [7:0] power_clamp;
  logic [7:0] out_format;
  logic [9:0] clamp_level;
  logic [1:0] sampler_gain;
  logic [9:0] amp_gain;
  logic [23:0] edge_loc;
  logic [1:0] next_sampler_gain;
  // only the three documented steps are accepted, others select 0 dB
  assign next_sampler_gain = (wr.data[1:0] == afe_out_pkg::GAIN_MINUS3 ||
    wr.data[1:0] == afe_out_pkg::GAIN_PLUS3) ? wr.data[1:0]
    : afe_out_pkg::GAIN_ZERO; // R21
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      power_clamp <= afe_out_pkg::RST_POWER_CLAMP;
      out_format <= afe_out_pkg::RST_OUT_FORMAT;
      clamp_level <= afe_out_pkg::RST_CLAMP_LEVEL;
      sampler_gain <= afe_out_pkg::RST_SAMPLER_GAIN; // R21
      amp_gain <= afe_out_pkg::RST_AMP_GAIN;
      edge_loc <= afe_out_pkg::RST_EDGE_LOC;
    end else if (wr_fire) begin
      case (wr.addr)
        afe_out_pkg::ADDR_POWER_CLAMP: power_clamp <= wr.data[7:0];
        afe_out_pkg::ADDR_OUT_FORMAT: out_format <= wr.data[7:0];
        afe_out_pkg::ADDR_CLAMP_LEVEL: clamp_level <= wr.data[9:0];
        afe_out_pkg::ADDR_SAMPLER_GAIN: sampler_gain <= next_sampler_gain;
        afe_out_pkg::ADDR_AMP_GAIN: amp_gain <= wr.data[9:0]; // R22
        afe_out_pkg::ADDR_EDGE_LOC: edge_loc <= wr.data;
        default: ;
      endcase
    end
  end
  // decoded fields
  wire clamp_en = power_clamp[afe_out_pkg::BIT_CLAMP_EN];
  wire restore_off_preblank_pulse = power_clamp[afe_out_pkg::BIT_RESTORE_OFF_PREBLANK_PULSE];
  wire [1:0] update_div = power_clamp[afe_out_pkg::POS_UPDATE_DIV +: 2];
  wire out_disable = out_format[afe_out_pkg::BIT_OUT_DISABLE];
  wire transparent = out_format[afe_out_pkg::BIT_TRANSPARENT];
  wire gray_sel = out_format[afe_out_pkg::BIT_GRAY];
  wire clk_fixed = out_format[afe_out_pkg::BIT_CLK_FIXED];
  wire clk_invert = out_format[afe_out_pkg::BIT_CLK_INVERT];
  wire [PHASE_W-1:0] ref_loc = edge_loc[afe_out_pkg::POS_REF_LOC +: PHASE_W];
  wire [PHASE_W-1:0] level_loc =
    edge_loc[afe_out_pkg::POS_LEVEL_LOC +: PHASE_W];
  wire [PHASE_W-1:0] latch_phase =
    edge_loc[afe_out_pkg::POS_LATCH_PHASE +: PHASE_W];

  //////////////////////////////////////////////////////////////////////
  // pixel phase counter: one edge position per clock
  logic [PHASE_W-1:0] phase;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) phase <= '0;
    else phase <= phase + 1'b1;
  end
  wire [PHASE_W-1:0] ref_rel = phase - ref_loc;
  wire [PHASE_W-1:0] level_rel = phase - level_loc;
  wire [PHASE_W-1:0] clk_base = clk_fixed ? '0 : latch_phase; // R5 R6
  wire [PHASE_W-1:0] clk_rel = phase - clk_base;
  wire latch_tick = (phase == latch_phase); // R1
  wire ref_win = ref_rel < PW_C; // R20
  wire level_win = level_rel < PW_C; // R20
  wire next_restore = ref_win && !(preblank_pulse_active && restore_off_preblank_pulse);
  wire next_word_clk = (clk_rel < HALF) ^ clk_invert; // R7

  // sample pulses and switch controls
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      REFERENCE_SAMPLE_PULSE <= 1'b0;
      LEVEL_SAMPLE_PULSE <= 1'b0;
      DC_RESTORE_CLOSE <= 1'b0;
      INPUT_GROUND <= 1'b0;
      PIXEL_WORD_CLOCK_OUT <= 1'b0;
      SAMPLER_GAIN <= afe_out_pkg::RST_SAMPLER_GAIN;
      AMP_GAIN <= afe_out_pkg::RST_AMP_GAIN;
    end else begin
      REFERENCE_SAMPLE_PULSE <= ref_win;
      LEVEL_SAMPLE_PULSE <= level_win;
      DC_RESTORE_CLOSE <= next_restore; // R16 R17
      INPUT_GROUND <= preblank_pulse_active; // R18
      PIXEL_WORD_CLOCK_OUT <= next_word_clk; // R5 R6 R7
      SAMPLER_GAIN <= sampler_gain; // R21
      AMP_GAIN <= amp_gain; // R22
    end
  end

  //////////////////////////////////////////////////////////////////////
  // pixel word path through the two-entry buffer
  logic [DATA_W-1:0] head;
  logic head_valid;
  logic pop;
  word_buffer #(.WIDTH(DATA_W), .DEPTH(2)) u_buf (
    .CLK(CLK),
    .RST(RST),
    .in_data(ADC_DATA),
    .in_valid(ADC_VALID),
    .in_ready(ADC_READY),
    .out_data(head),
    .out_valid(head_valid),
    .out_ready(pop)
  );
  // a stalled receiver holds words in the buffer
  assign pop = head_valid && PIX_READY && (transparent || latch_tick); // R1 R2
  wire [DATA_W-1:0] gray_word = head ^ (head >> 1); // R23
  wire [DATA_W-1:0] coded = gray_sel ? gray_word : head; // R4
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PIX_DATA <= '0;
      PIX_VALID <= 1'b0;
      PIX_DATA_OE <= 1'b0;
    end else begin
      PIX_DATA_OE <= !out_disable; // R3 R24
      PIX_VALID <= pop && !out_disable; // R24
      if (pop) PIX_DATA <= coded; // R1 R2 R4
    end
  end

  //////////////////////////////////////////////////////////////////////
  // optical black clamp loop
  localparam int ACC_W = DATA_W + 12;
  logic [9:0] target;
  logic signed [ACC_W-1:0] acc;
  logic signed [CORR_W-1:0] corr;
  logic [1:0] line_cnt;
  logic signed [ACC_W-1:0] step;
  logic signed [ACC_W-1:0] next_corr_w;
  // target in LSB: code scaled so 1023 steps span 0..255
  assign target = 10'((20'(clamp_level) * 20'(afe_out_pkg::TARGET_FULL_LSB))
    / 20'(afe_out_pkg::TARGET_FULL_CODE)); // R13
  wire black_sample = clamp_s && !preblank_pulse_active && ADC_VALID && ADC_READY;
  wire signed [ACC_W-1:0] err =
    ACC_W'($signed({1'b0, ADC_DATA})) - ACC_W'($signed({1'b0, target}));
  wire update_line = clamp_fall && (line_cnt == update_div); // R14
  assign step = acc >>> FILT_SHIFT;
  assign next_corr_w = ACC_W'(corr) - step;
  wire signed [ACC_W-1:0] corr_max = ACC_W'((1 << (CORR_W - 1)) - 1);
  wire signed [ACC_W-1:0] corr_min = -ACC_W'(1 << (CORR_W - 1));
  wire signed [CORR_W-1:0] corr_sat = (next_corr_w > corr_max) ?
    CORR_W'(corr_max) : (next_corr_w < corr_min) ? CORR_W'(corr_min)
    : CORR_W'(next_corr_w);
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      acc <= '0;
      corr <= '0;
      line_cnt <= '0;
    end else begin
      if (clamp_fall) acc <= '0;
      else if (black_sample && clamp_en) acc <= acc + err; // R12
      if (clamp_fall) line_cnt <= update_line ? '0 : line_cnt + 1'b1;
      if (update_line && clamp_en) corr <= corr_sat; // R10 R12 R14
    end
  end
  // disabled loop: level code still adds a fixed offset
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) CLAMP_DAC <= '0;
    else if (clamp_en) CLAMP_DAC <= corr; // R12
    else CLAMP_DAC <= -$signed(CORR_W'(target)); // R10 R11
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  AST_LATCH_PHASE: assert property (PIX_VALID |->
    $past(transparent) || ($past(phase) == $past(latch_phase))) // R1
    else $error("word captured off latch phase");
  AST_TRANSPARENT: assert property (transparent && !out_disable &&
    head_valid && PIX_READY |=> PIX_VALID) // R2
    else $error("transparent word not passed");
  AST_DISABLE: assert property (out_disable |=> !PIX_DATA_OE && !PIX_VALID)
    // R3 R24
    else $error("outputs driven while disabled");
  AST_GRAY: assert property (pop && gray_sel |=>
    PIX_DATA == ($past(head) ^ ($past(head) >> 1))) // R4 R23
    else $error("gray coding wrong");
  AST_BINARY: assert property (pop && !gray_sel |=> PIX_DATA == $past(head))
    // R4
    else $error("binary word wrong");
  AST_CLK_TRACK: assert property (!clk_fixed && !clk_invert &&
    $stable(latch_phase) && phase == latch_phase |=>
    PIXEL_WORD_CLOCK_OUT ##1 PIXEL_WORD_CLOCK_OUT) // R5
    else $error("word clock not aligned to latch phase");
  AST_CLK_FIXED: assert property (clk_fixed && !clk_invert &&
    phase == HALF |=> !PIXEL_WORD_CLOCK_OUT) // R6
    else $error("fixed word clock phase wrong");
  AST_CLK_INV: assert property ($stable(out_format) && $stable(latch_phase)
    |=> PIXEL_WORD_CLOCK_OUT == ($past(next_word_clk))) // R7
    else $error("word clock polarity wrong");
  AST_CLAMP_OFF: assert property (!clamp_en ##1 !clamp_en |=>
    CLAMP_DAC == -$signed(CORR_W'($past(target)))) // R10 R11
    else $error("fixed clamp offset wrong");
  AST_RESTORE: assert property (DC_RESTORE_CLOSE |->
    $past(ref_win) && !($past(preblank_pulse_active) && $past(restore_off_preblank_pulse)))
    // R16 R17
    else $error("dc restore closed outside reference pulse");
  AST_GROUND: assert property (preblank_pulse_active |=> INPUT_GROUND) // R18
    else $error("input not grounded in preblank");
  AST_GAIN: assert property (SAMPLER_GAIN != 2'h3) // R21
    else $error("illegal sampler gain step");
  AST_NO_LOSS: assert property (head_valid && !pop |=>
    head_valid && $stable(head)) // R1
    else $error("stalled word lost");
endmodule // afe_out_ctrl
`default_nettype wire

/* File: dv/pixel_sink.sv */
// downstream image processor model that latches pixel words
`timescale 1ns/1ps
`default_nettype none
module pixel_sink #(
  parameter int W = 14
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [W-1:0] pix_data,
  input wire logic pix_oe,
  input wire logic pix_valid,
  input wire logic word_clk,
  input wire logic [1:0] mode,
  output logic ready,
  output logic got,
  output logic [W:0] got_word
);
  logic [W-1:0] bus;
  logic [7:0] lfsr;
  // a released bus shows the inverse of the last captured word
  assign bus = pix_oe ? pix_data : ~got_word[W-1:0];
  // latch word and word clock on the valid pulse; ready prompt/random/held
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      lfsr <= 8'h5A;
      ready <= 1'b0;
      got <= 1'b0;
      got_word <= '0;
    end else begin
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      ready <= (mode == 2'h0) | ((mode == 2'h1) & lfsr[0]);
      got <= pix_valid;
      if (pix_valid) begin
        got_word <= {word_clk, bus};
      end
    end
  end
endmodule // pixel_sink
`default_nettype wire

/* File: dv/tb_ccd_afe_control_and_output.sv */
// testbench of the front end control and pixel output block
`timescale 1ns/1ps
`default_nettype none
module tb_ccd_afe_control_and_output;
  logic CLK, RST, SL_N, SCK, SDI, ADC_VALID, ADC_READY, PIX_READY, got;
  logic PREBLANK_PULSE_N, BLACK_CLAMP_PULSE, PIX_DATA_OE, PIX_VALID;
  logic PIXEL_WORD_CLOCK_OUT, REFERENCE_SAMPLE_PULSE, LEVEL_SAMPLE_PULSE;
  logic DC_RESTORE_CLOSE, INPUT_GROUND, gray, dis, spc, taken;
  logic [13:0] ADC_DATA, PIX_DATA;
  logic [1:0] SAMPLER_GAIN, sink_mode;
  logic [9:0] AMP_GAIN;
  logic signed [11:0] CLAMP_DAC;
  logic [14:0] got_word;
  logic [15:0] expq[$];
  logic [15:0] exp_e;
  logic [31:0] seed = 32'h350C9E8A;
  logic [31:0] r;
  int errors, check_count, cyc, prev, nref, nlev, nres, ngnd, dr;

  afe_out_ctrl afe_out_ctrl_i (.CLK(CLK), .RST(RST), .SL_N(SL_N), .SCK(SCK),
    .SDI(SDI), .ADC_DATA(ADC_DATA), .ADC_VALID(ADC_VALID),
    .ADC_READY(ADC_READY), .PIX_READY(PIX_READY),
    .PREBLANK_PULSE_N(PREBLANK_PULSE_N),
    .BLACK_CLAMP_PULSE(BLACK_CLAMP_PULSE), .PIX_DATA(PIX_DATA),
    .PIX_DATA_OE(PIX_DATA_OE), .PIX_VALID(PIX_VALID),
    .PIXEL_WORD_CLOCK_OUT(PIXEL_WORD_CLOCK_OUT),
    .REFERENCE_SAMPLE_PULSE(REFERENCE_SAMPLE_PULSE),
    .LEVEL_SAMPLE_PULSE(LEVEL_SAMPLE_PULSE),
    .DC_RESTORE_CLOSE(DC_RESTORE_CLOSE), .INPUT_GROUND(INPUT_GROUND),
    .SAMPLER_GAIN(SAMPLER_GAIN), .AMP_GAIN(AMP_GAIN), .CLAMP_DAC(CLAMP_DAC));
  pixel_sink pixel_sink_i (.CLK(CLK), .RST(RST), .pix_data(PIX_DATA),
    .pix_oe(PIX_DATA_OE), .pix_valid(PIX_VALID),
    .word_clk(PIXEL_WORD_CLOCK_OUT), .mode(sink_mode), .ready(PIX_READY),
    .got(got), .got_word(got_word));

  // 40 MHz clock
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [15:0] a, e, input string msg);
    check_count++;
    if (a !== e) begin
      errors++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic test_done();
    $display("errors=%0d check_count=%0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // serial frame: 8 address then 24 data bits, msb first, 200 ns bit clock
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    logic [31:0] f;
    f = {a, d};
    SL_N = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      SDI = f[i];
      repeat (4) @(negedge CLK);
      SCK = 1'b1;
      repeat (4) @(negedge CLK);
      SCK = 1'b0;
    end
    repeat (4) @(negedge CLK);
    SL_N = 1'b1;
    repeat (8) @(negedge CLK);
  endtask
  // offer a word; note the expected output once it is taken
  task automatic send(input logic [13:0] w, input int tries,
                      input logic [1:0] ck);
    logic [13:0] e;
    e = gray ? (w ^ (w >> 1)) : w;
    ADC_DATA = w;
    ADC_VALID = 1'b1;
    taken = 1'b0;
    for (int i = 0; i < tries && !taken; i++) begin
      if (ADC_READY === 1'b1) begin
        @(posedge CLK);
        if (!dis)
          expq.push_back({ck, e});
        taken = 1'b1;
      end
      @(negedge CLK);
    end
  endtask
  task automatic drain();
    for (int i = 0; i < 600 && expq.size() > 0; i++) @(negedge CLK);
    if (expq.size() > 0) begin
      check(16'h0001, 16'h0000, "words lost");
      test_done();
    end
    repeat (4) @(negedge CLK);
  endtask
  // count pulse levels over two pixel phase periods and find the first rises of the two sample pulses
  task automatic meas();
    int rr, lr;
    logic pr, pl;
    rr = -1;
    lr = -1;
    pr = 1'b1;
    pl = 1'b1;
    {nref, nlev, nres, ngnd} = '0;
    for (int i = 0; i < 128; i++) begin
      @(negedge CLK);
      nref += REFERENCE_SAMPLE_PULSE;
      nlev += LEVEL_SAMPLE_PULSE;
      nres += DC_RESTORE_CLOSE;
      ngnd += INPUT_GROUND;
      if (REFERENCE_SAMPLE_PULSE && !pr && rr < 0) rr = i;
      if (LEVEL_SAMPLE_PULSE && !pl && lr < 0) lr = i;
      pr = REFERENCE_SAMPLE_PULSE;
      pl = LEVEL_SAMPLE_PULSE;
    end
    dr = (lr - rr + 128) % 64;
  endtask
  // three words in phase mode with a given location and format setting
  task automatic batch(input logic [23:0] loc, input logic [7:0] fmt,
                       input logic [1:0] ck);
    wr(8'h37, loc);
    wr(8'h01, {16'h0000, fmt});
    spc = 1'b1;
    prev = 0;
    for (int i = 0; i < 3; i++) begin
      r = rnd();
      send(r[13:0], 300, ck);
    end
    ADC_VALID = 1'b0;
    drain();
    spc = 1'b0;
  endtask
  // receiver side: compare each captured word with the oldest note
  always @(negedge CLK) begin
    cyc++;
    if (got === 1'b1) begin
      if (expq.size() == 0) begin
        check(16'h0001, 16'h0000, "unexpected word");
      end else begin
        exp_e = expq.pop_front();
        check({2'h0, got_word[13:0]}, {2'h0, exp_e[13:0]}, "word");
        if (exp_e[15])
          check(16'(got_word[14]), 16'(exp_e[14]), "clock");
        if (spc && prev > 0)
          check(16'(cyc - prev), 16'h0040, "spacing");
        prev = cyc;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {RST, SL_N, PREBLANK_PULSE_N} = 3'h7;
    {SCK, SDI, ADC_VALID, BLACK_CLAMP_PULSE, gray, dis, spc} = '0;
    ADC_DATA = 14'h0000;
    sink_mode = 2'h0;
    repeat (5) @(negedge CLK);
    RST = 1'b0;
    repeat (4) @(negedge CLK);
    check(16'(SAMPLER_GAIN), 16'h0001, "gain reset");
    check(16'(ADC_READY), 16'h0001, "ready reset");
    for (int i = 0; i < 4; i++) begin
      wr(8'h04, 24'(i));
      check(16'(SAMPLER_GAIN), (i == 3) ? 16'h0001 : 16'(i), "gain");
    end
    r = rnd();
    wr(8'h05, {14'h0000, r[9:0]});
    check(16'(AMP_GAIN), {6'h00, r[9:0]}, "amp gain");
    wr(8'h01, 24'h000002);
    BLACK_CLAMP_PULSE = 1'b1;
    repeat (4) @(negedge CLK);
    for (int i = 0; i < 4; i++) send(14'h0040, 300, 2'h0);
    ADC_VALID = 1'b0;
    repeat (20) @(negedge CLK);
    BLACK_CLAMP_PULSE = 1'b0;
    repeat (8) @(negedge CLK);
    check({4'h0, CLAMP_DAC}, 16'h0FF0, "clamp loop");
    drain();
    sink_mode = 2'h1;
    for (int g = 0; g < 2; g++) begin
      if (g == 1)
        wr(8'h01, 24'h000006);
      gray = g[0];
      for (int i = 0; i < 12; i++) begin
        r = rnd();
        send(r[13:0], 300, 2'h0);
      end
      ADC_VALID = 1'b0;
      drain();
    end
    sink_mode = 2'h2;
    taken = 1'b1;
    for (int i = 0; i < 8 && taken; i++) begin
      r = rnd();
      send(r[13:0], 1, 2'h0);
    end
    check(16'(ADC_READY), 16'h0000, "buffer full");
    ADC_VALID = 1'b0;
    sink_mode = 2'h1;
    drain();
    dis = 1'b1;
    wr(8'h01, 24'h000007);
    for (int i = 0; i < 3; i++) send(14'h1555, 300, 2'h0);
    ADC_VALID = 1'b0;
    repeat (200) @(negedge CLK);
    check(16'(PIX_DATA_OE), 16'h0000, "three-state");
    check(16'(ADC_READY), 16'h0001, "drain while off");
    {dis, gray} = 2'h0;
    sink_mode = 2'h0;
    wr(8'h37, 24'h102804);
    wr(8'h01, 24'h000000);
    meas();
    check(16'(nref), 16'h0010, "ref width");
    check(16'(nlev), 16'h0010, "level width");
    check(16'(dr), 16'h0024, "edge distance");
    check(16'(nres), 16'h0010, "restore");
    batch(24'h102804, 8'h00, 2'h3);
    batch(24'h300828, 8'h00, 2'h3);
    batch(24'h300828, 8'h08, 2'h2);
    batch(24'h102804, 8'h08, 2'h3);
    batch(24'h102804, 8'h10, 2'h2);
    wr(8'h00, 24'h000044);
    PREBLANK_PULSE_N = 1'b0;
    repeat (4) @(negedge CLK);
    meas();
    check(16'(nres), 16'h0000, "restore off");
    check(16'(ngnd), 16'h0080, "grounded");
    wr(8'h00, 24'h000004);
    meas();
    check(16'(nres), 16'h0010, "restore kept");
    PREBLANK_PULSE_N = 1'b1;
    repeat (4) @(negedge CLK);
    meas();
    check(16'(ngnd), 16'h0000, "released");
    wr(8'h00, 24'h000000);
    wr(8'h03, 24'h0003FF);
    check({4'h0, CLAMP_DAC}, 16'h0F01, "fixed offset");
    wr(8'h03, 24'h000200);
    check({4'h0, CLAMP_DAC}, 16'h0F81, "mid target");
    test_done();
  end
endmodule // tb_ccd_afe_control_and_output
`default_nettype wire
